// ==== hw/qbp_consts.svh ====
/*
 Timing counts, reset values and bit positions for the quasi-bidirectional ports.
 Assumes inclusion by bare name from the port module.
*/
`ifndef QBP_CONSTS_SVH
`define QBP_CONSTS_SVH
`define QBP_LATCH_RESET      8'hFF
`define QBP_CLK_PERIOD_NS    10
`define QBP_CYCLE_CLOCKS     4
`define QBP_PULSE_TIME_NS    20
`define QBP_PULSE_CYCLES     ((`QBP_PULSE_TIME_NS + `QBP_CLK_PERIOD_NS - 1) / `QBP_CLK_PERIOD_NS)
`define QBP_MOVE_CYCLES      2
`define QBP_ALE_PHASE        2'h0
`define QBP_BIT_RX           0
`define QBP_BIT_TX           1
`define QBP_BIT_INTA         2
`define QBP_BIT_INTB         3
`define QBP_BIT_TMRA         4
`define QBP_BIT_TMRB         5
`define QBP_BIT_WR           6
`define QBP_BIT_RD           7
`endif

// ==== hw/qbp_pkg.sv ====
/*
 Types for the quasi-bidirectional port block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package qbp_pkg;
    typedef enum logic [1:0] {QBP_IDLE, QBP_ADDR, QBP_DATA} qbp_move_t;
endpackage

// ==== hw/qbp_ports.sv ====
/*
 Two quasi-bidirectional 8-bit ports with alternate functions, machine-cycle timing
 and the address-latch pulse. Assumes the core drives latch writes and move requests
 on CLK, and that pins resolve strong-low, strong-high and weak-pullup outside.
*/
`timescale 1ns/1ns
`include "qbp_consts.svh"
module qbp_ports (
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       UPPER_WRITE,
    input  wire logic       ALT_WRITE,
    input  wire logic [7:0] WRITE_DATA,
    input  wire logic       BUS_MODE,
    input  wire logic [7:0] BUS_ADDR_HIGH,
    input  wire logic       MOVE_REQ,
    input  wire logic       MOVE_READ,
    input  wire logic       FETCH_EXTERNAL,
    input  wire logic       REDUCED_EMISSION,
    input  wire logic       SERIAL0_TRANSMIT_OUT,
    input  wire logic       EXTERNAL_ACCESS_N,
    input  wire logic [7:0] UPPER_ADDRESS_PORT_IN,
    input  wire logic [7:0] ALT_FUNCTION_PORT_IN,
    output logic [7:0]      UPPER_ADDRESS_PORT_OUT,
    output logic [7:0]      UPPER_ADDRESS_PORT_OE,
    output logic [7:0]      ALT_FUNCTION_PORT_OUT,
    output logic [7:0]      ALT_FUNCTION_PORT_OE,
    output logic [7:0]      UPPER_LATCH,
    output logic [7:0]      ALT_LATCH,
    output logic [7:0]      UPPER_PIN_LEVEL,
    output logic [7:0]      ALT_PIN_LEVEL,
    output logic            SERIAL0_RECEIVE_IN,
    output logic            EXT_INTERRUPT_A_N,
    output logic            EXT_INTERRUPT_B_N,
    output logic            TIMER_A_INPUT,
    output logic            TIMER_B_INPUT,
    output logic            FETCH_FROM_EXTERNAL,
    output logic            ADDRESS_LATCH_PULSE,
    output logic            MOVE_BUSY,
    output logic            MOVE_DONE
);
    logic [7:0]       up_sync1, up_sync2, alt_sync1, alt_sync2;
    logic             xacc_sync1, xacc_sync2;
    logic [1:0]       phase;
    logic [7:0]       up_boost, alt_boost;
    logic [1:0]       up_boost_cnt [8];
    logic [1:0]       alt_boost_cnt [8];
    qbp_pkg::qbp_move_t move_state;
    logic [7:0]       move_addr;
    logic             move_rd;
    logic [7:0]       up_drive_val, alt_drive_val, alt_func_val;
    logic [7:0]       up_strong, alt_strong;
    logic [7:0]       up_rise, alt_rise;
    wire              cycle_end = (phase == 2'(`QBP_CYCLE_CLOCKS - 1));
    wire              bus_busy  = (move_state != qbp_pkg::QBP_IDLE);
    wire              latch_need = FETCH_EXTERNAL | bus_busy | MOVE_REQ;
    wire logic [1:0]  pulse_len = 2'(`QBP_PULSE_CYCLES);
    wire              data_cycle = (move_state == qbp_pkg::QBP_DATA);
    wire              bus_drive  = bus_busy | BUS_MODE;

    // Synchronisers; only stage two is read
    // No reset: they only follow the pins
    always_ff @(posedge CLK) begin
        up_sync1   <= UPPER_ADDRESS_PORT_IN;
        up_sync2   <= up_sync1;
        alt_sync1  <= ALT_FUNCTION_PORT_IN;
        alt_sync2  <= alt_sync1;
        xacc_sync1 <= EXTERNAL_ACCESS_N;
        xacc_sync2 <= xacc_sync1;
    end

    // Pins read back the outside level over the weak pullup
    assign UPPER_PIN_LEVEL     = up_sync2;
    assign ALT_PIN_LEVEL       = alt_sync2;
    assign SERIAL0_RECEIVE_IN  = alt_sync2[`QBP_BIT_RX];
    assign EXT_INTERRUPT_A_N   = alt_sync2[`QBP_BIT_INTA];
    assign EXT_INTERRUPT_B_N   = alt_sync2[`QBP_BIT_INTB];
    assign TIMER_A_INPUT       = alt_sync2[`QBP_BIT_TMRA];
    assign TIMER_B_INPUT       = alt_sync2[`QBP_BIT_TMRB];
    assign FETCH_FROM_EXTERNAL = ~xacc_sync2;

    // Machine cycle phase counter
    // Free-running, so move timing and the pulse share one boundary
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // Latch pulse in phase 0; suppressed when no bus use under reduced emission
    // Registered so the pin sees no decode glitch
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ADDRESS_LATCH_PULSE <= 1'b0;
        end else begin
            ADDRESS_LATCH_PULSE <= cycle_end & (~REDUCED_EMISSION | latch_need);
        end
    end

    // Port latches
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            UPPER_LATCH <= `QBP_LATCH_RESET;
            ALT_LATCH   <= `QBP_LATCH_RESET;
        end else begin
            if (UPPER_WRITE) begin
                UPPER_LATCH <= WRITE_DATA;
            end
            if (ALT_WRITE) begin
                ALT_LATCH <= WRITE_DATA;
            end
        end
    end

    // Rising bits: a written one over a latched zero
    // Rewriting an unchanged value starts no boost
    assign up_rise  = UPPER_WRITE ? (WRITE_DATA & ~UPPER_LATCH) : 8'h00;
    assign alt_rise = ALT_WRITE ? (WRITE_DATA & ~ALT_LATCH) : 8'h00;

    // Brief strong-high boost per bit after a zero-to-one write
    for (genvar i = 0; i < 8; i++) begin : g_boost
        always_ff @(posedge CLK) begin
            if (!NRST) begin
                up_boost_cnt[i]  <= 2'h0;
                alt_boost_cnt[i] <= 2'h0;
            end else begin
                // A new rise restarts the count
                if (up_rise[i]) begin
                    up_boost_cnt[i] <= pulse_len;
                end else if (up_boost_cnt[i] != 2'h0) begin
                    up_boost_cnt[i] <= up_boost_cnt[i] - 2'h1;
                end
                if (alt_rise[i]) begin
                    alt_boost_cnt[i] <= pulse_len;
                end else if (alt_boost_cnt[i] != 2'h0) begin
                    alt_boost_cnt[i] <= alt_boost_cnt[i] - 2'h1;
                end
            end
        end
        assign up_boost[i]  = (up_boost_cnt[i] != 2'h0);
        assign alt_boost[i] = (alt_boost_cnt[i] != 2'h0);
    end

    // External data move: address cycle then data cycle
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            move_state <= qbp_pkg::QBP_IDLE;
            move_addr  <= 8'h00;
            move_rd    <= 1'b0;
            MOVE_DONE  <= 1'b0;
        end else begin
            MOVE_DONE <= 1'b0;
            case (move_state)
                qbp_pkg::QBP_IDLE: begin
                    // Direction and address frozen at the take edge
                    if (MOVE_REQ && cycle_end) begin
                        move_state <= qbp_pkg::QBP_ADDR;
                        move_addr  <= BUS_ADDR_HIGH;
                        move_rd    <= MOVE_READ;
                    end
                end
                qbp_pkg::QBP_ADDR: begin
                    if (cycle_end) begin
                        move_state <= qbp_pkg::QBP_DATA;
                    end
                end
                default: begin
                    if (cycle_end) begin
                        move_state <= qbp_pkg::QBP_IDLE;
                        MOVE_DONE  <= 1'b1;
                    end
                end
            endcase
        end
    end
    assign MOVE_BUSY = bus_busy;

    // Strobe low only in the data cycle; bus drive needs latch one
    always_comb begin
        alt_func_val = 8'hFF;
        alt_func_val[`QBP_BIT_TX] = SERIAL0_TRANSMIT_OUT;
        alt_func_val[`QBP_BIT_WR] = ~(data_cycle & ~move_rd);
        alt_func_val[`QBP_BIT_RD] = ~(data_cycle & move_rd);
    end

    // Latch zero wins, so a bus value can never override a pulldown
    assign up_drive_val  = UPPER_LATCH & (bus_busy ? move_addr :
                           (BUS_MODE ? BUS_ADDR_HIGH : 8'hFF));
    assign alt_drive_val = ALT_LATCH & alt_func_val;

    // Strong drive: low always, high during boost or bus address
    assign up_strong  = ~up_drive_val | up_boost | (bus_drive ? UPPER_LATCH : 8'h00);
    assign alt_strong = ~alt_drive_val | alt_boost;

    // Reset leaves every pin on the weak pullup
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            UPPER_ADDRESS_PORT_OUT <= 8'hFF;
            UPPER_ADDRESS_PORT_OE  <= 8'h00;
            ALT_FUNCTION_PORT_OUT  <= 8'hFF;
            ALT_FUNCTION_PORT_OE   <= 8'h00;
        end else begin
            UPPER_ADDRESS_PORT_OUT <= up_drive_val;
            UPPER_ADDRESS_PORT_OE  <= up_strong;
            ALT_FUNCTION_PORT_OUT  <= alt_drive_val;
            ALT_FUNCTION_PORT_OE   <= alt_strong;
        end
    end
endmodule // qbp_ports

// ==== test/qbp_ports_properties.sv ====
/* Checker for the port block: pulldown, boost, latch pulse, move timing.
   Assumes it is bound to qbp_ports and sees only its ports. */
`timescale 1ns/1ns
module qbp_ports_properties (
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       MOVE_REQ,
    input wire logic       FETCH_EXTERNAL,
    input wire logic       REDUCED_EMISSION,
    input wire logic       EXTERNAL_ACCESS_N,
    input wire logic [7:0] UPPER_ADDRESS_PORT_OUT,
    input wire logic [7:0] UPPER_ADDRESS_PORT_OE,
    input wire logic [7:0] UPPER_LATCH,
    input wire logic [7:0] ALT_LATCH,
    input wire logic [7:0] ALT_FUNCTION_PORT_OUT,
    input wire logic [7:0] ALT_FUNCTION_PORT_OE,
    input wire logic       FETCH_FROM_EXTERNAL,
    input wire logic       ADDRESS_LATCH_PULSE,
    input wire logic       MOVE_BUSY,
    input wire logic       MOVE_DONE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire need = !REDUCED_EMISSION || FETCH_EXTERNAL || MOVE_REQ || MOVE_BUSY;
    property p_reset_ones;
        $rose(NRST) |-> UPPER_LATCH == 8'hFF && ALT_LATCH == 8'hFF;
    endproperty
    a_reset_ones: assert property (p_reset_ones) else $error("latch not all ones after reset");
    property p_pulldown;
        $stable(UPPER_LATCH) |-> (UPPER_ADDRESS_PORT_OE | UPPER_LATCH) == 8'hFF
            && (UPPER_ADDRESS_PORT_OUT & ~UPPER_LATCH) == 8'h00;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("zero bit not pulled down");
    property p_boost;
        |(UPPER_LATCH & ~$past(UPPER_LATCH)) |-> ##1 ((UPPER_ADDRESS_PORT_OE & UPPER_ADDRESS_PORT_OUT) != 8'h00) [*2];
    endproperty
    a_boost: assert property (p_boost) else $error("no strong high after rising bit");
    property p_ale_gap;
        ADDRESS_LATCH_PULSE |=> !ADDRESS_LATCH_PULSE [*3] ##1 (ADDRESS_LATCH_PULSE || $past(REDUCED_EMISSION));
    endproperty
    a_ale_gap: assert property (p_ale_gap) else $error("latch pulse spacing wrong");
    property p_ale_need;
        ADDRESS_LATCH_PULSE |-> $past(need);
    endproperty
    a_ale_need: assert property (p_ale_need) else $error("unneeded latch pulse");
    property p_move;
        $rose(MOVE_BUSY) |-> MOVE_BUSY [*8] ##1 MOVE_DONE;
    endproperty
    a_move: assert property (p_move) else $error("move not two machine cycles");
    property p_strobe;
        ALT_FUNCTION_PORT_OE[7] && !ALT_FUNCTION_PORT_OUT[7] && ALT_LATCH[7] && $past(ALT_LATCH[7]) |-> $past(MOVE_BUSY);
    endproperty
    a_strobe: assert property (p_strobe) else $error("read strobe outside a move");
    property p_fetch;
        FETCH_FROM_EXTERNAL == !$past(EXTERNAL_ACCESS_N, 2);
    endproperty
    a_fetch: assert property (p_fetch) else $error("program source select wrong");
    c_move: cover property (MOVE_DONE);
    c_boost: cover property (|(UPPER_LATCH & ~$past(UPPER_LATCH)));
    c_quiet: cover property ((REDUCED_EMISSION && !ADDRESS_LATCH_PULSE) [*8]);
endmodule // qbp_ports_properties

// ==== test/qbp_pin_model.sv ====
/* Far-side pin model: strong drive, outside circuit or weak pullup.
   Assumes one instance per 8-bit port. */
`timescale 1ns/1ns
module qbp_pin_model (
    input  wire logic [7:0] drv_out,
    input  wire logic [7:0] drv_oe,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic [7:0]      pin
);
    // Outside circuit beats only the weak pullup
    assign pin = (drv_oe & drv_out) | (~drv_oe & ((ext_en & ext_val) | ~ext_en));
endmodule // qbp_pin_model

// ==== test/quasi_bidir_port_ext_bus_tb_top.sv ====
/* Bench for the port block: writes, boost, inputs, moves, latch pulse.
   Assumes the port block, its checker and the pin model. */
`timescale 1ns/1ns
module quasi_bidir_port_ext_bus_tb_top;
    logic       clk = 0, nrst = 0, up_w = 0, alt_w = 0, bus = 0, mreq = 0, mrd = 0, fetch = 0, red = 0;
    logic       xacc_n = 1, tx = 1;
    logic [7:0] wdata = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] up_out, up_oe, alt_out, alt_oe, up_lat, alt_lat, up_pin, alt_pin, up_lvl, alt_lvl;
    logic       rx, ia, ib, ta, tmb, fx, ale, busy, done;
    int         n_errors = 0, n_checks = 0, cycles = 0, n;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end
    qbp_pin_model qbp_pin_model_up_inst (.drv_out(up_out), .drv_oe(up_oe), .ext_en(8'h00), .ext_val(8'h00),
        .pin(up_pin));
    qbp_pin_model qbp_pin_model_alt_inst (.drv_out(alt_out), .drv_oe(alt_oe), .ext_en(ext_en), .ext_val(ext_val),
        .pin(alt_pin));
    qbp_ports qbp_ports_inst (.CLK(clk), .NRST(nrst), .UPPER_WRITE(up_w), .ALT_WRITE(alt_w), .WRITE_DATA(wdata),
        .BUS_MODE(bus), .BUS_ADDR_HIGH(8'hA5), .MOVE_REQ(mreq), .MOVE_READ(mrd), .FETCH_EXTERNAL(fetch),
        .REDUCED_EMISSION(red), .SERIAL0_TRANSMIT_OUT(tx), .EXTERNAL_ACCESS_N(xacc_n),
        .UPPER_ADDRESS_PORT_IN(up_pin), .ALT_FUNCTION_PORT_IN(alt_pin), .UPPER_ADDRESS_PORT_OUT(up_out),
        .UPPER_ADDRESS_PORT_OE(up_oe), .ALT_FUNCTION_PORT_OUT(alt_out), .ALT_FUNCTION_PORT_OE(alt_oe),
        .UPPER_LATCH(up_lat), .ALT_LATCH(alt_lat), .UPPER_PIN_LEVEL(up_lvl), .ALT_PIN_LEVEL(alt_lvl),
        .SERIAL0_RECEIVE_IN(rx), .EXT_INTERRUPT_A_N(ia), .EXT_INTERRUPT_B_N(ib), .TIMER_A_INPUT(ta),
        .TIMER_B_INPUT(tmb), .FETCH_FROM_EXTERNAL(fx), .ADDRESS_LATCH_PULSE(ale), .MOVE_BUSY(busy),
        .MOVE_DONE(done));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task wr(input logic d_alt, input logic [7:0] d);
        @(posedge clk) wdata <= d;
        up_w <= !d_alt;
        alt_w <= d_alt;
        @(posedge clk) up_w <= 0;
        alt_w <= 0;
    endtask
    task t_write;
        wr(0, 8'h00);
        tick(2);
        chk(up_out | ~up_oe, 8'h00);
        tick(1);
        chk(up_lvl, 8'h00);
        wr(0, 8'hFF);
        tick(1);
        chk(up_out & up_oe, 8'hFF);
        tick(1);
        chk(up_oe, 8'hFF);
        tick(1);
        chk(up_oe, 8'h00);
    endtask
    task t_alt;
        wr(1, 8'h7F);
        tick(2);
        chk({6'h00, alt_oe[7], alt_out[7]}, 8'h02);
        wr(1, 8'hFF);
        tick(1);
        chk({6'h00, alt_oe[7], alt_out[7]}, 8'h03);
        tick(3);
        chk(alt_oe, 8'h00);
        @(posedge clk) tx <= 0;
        tick(2);
        chk({6'h00, alt_oe[1], alt_out[1]}, 8'h02);
        @(posedge clk) tx <= 1;
        tick(2);
        chk(alt_oe, 8'h00);
    endtask
    task t_input;
        @(posedge clk) ext_val <= 8'h35;
        ext_en <= 8'hFF;
        tick(3);
        chk(alt_lvl, 8'h35);
        chk({3'h0, tmb, ta, ib, ia, rx}, 8'h1B);
        @(posedge clk) ext_en <= 8'h00;
    endtask
    task t_move(input logic rd);
        @(posedge clk) mreq <= 1;
        mrd <= rd;
        n = 0;
        while (!busy && n < 8) begin
            tick(1);
            n++;
        end
        @(posedge clk) mreq <= 0;
        #1 n = 1;
        while (!done && n < 12) begin
            if (n == 2) chk(up_out, 8'hA5);
            if (n == 7) chk({6'h00, alt_oe[rd ? 7 : 6], alt_out[rd ? 7 : 6]}, 8'h02);
            tick(1);
            n++;
        end
        chk(8'(n), 8'h08);
    endtask
    task t_ale(input logic r, input logic f, input logic [7:0] exp);
        @(posedge clk) red <= r;
        fetch <= f;
        tick(4);
        n = 0;
        repeat (40) begin
            tick(1);
            n += ale;
        end
        chk(8'(n), exp);
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        #1 chk(up_lat & alt_lat, 8'hFF);
        chk(up_oe | alt_oe, 8'h00);
        t_write();
        t_alt();
        t_input();
        @(posedge clk) bus <= 1;
        t_move(1);
        t_move(0);
        t_ale(0, 0, 8'h0A);
        t_ale(1, 0, 8'h00);
        t_ale(1, 1, 8'h0A);
        @(posedge clk) xacc_n <= 0;
        tick(3);
        chk({7'h0, fx}, 8'h01);
        test_done();
    end
endmodule // quasi_bidir_port_ext_bus_tb_top
bind qbp_ports qbp_ports_properties qbp_ports_properties_inst (.*);
